// ### rtl/edge_blank_consts.svh
/*
 * register offsets, field positions, reset values and widths for the edge source
 * and blanking block.
 * assumes inclusion by bare name from the block module and the bench top module.
 */
`ifndef EDGE_BLANK_CONSTS_SVH
`define EDGE_BLANK_CONSTS_SVH

`define FBS_OFFSET 12'h000
`define PHS_OFFSET 12'h004
`define BLANK_OFFSET 12'h008
`define TIMEBASE_OFFSET 12'h00C
`define PHASEVAL_OFFSET 12'h010
`define STATUS_OFFSET 12'h014

`define FBS_MASK 8'h8E
`define PHS_MASK 8'h8F
`define SRC_EXT_BIT 7
`define SRC_CMP3_BIT 3
`define SRC_CMP2_BIT 2
`define SRC_CMP1_BIT 1
`define SRC_TB_BIT 0
`define REG_RESET 8'h00
`define BLANK_RESET 8'h00
`define WORD_RESET 16'h0000
`define BLANK_ZERO 8'h00
`define BLANK_ONE 8'h01

`endif

// ### rtl/edge_blank_pkg.sv
/*
 * types shared by the edge source and blanking block.
 * assumes the constants header is on the include path.
 */
`default_nettype none

package edge_blank_pkg;
	typedef enum logic [1:0] {
		st_idle_type = 2'h1,
		st_blank_type = 2'h2
	} blank_state_type;

	typedef struct packed {
		logic ext;
		logic cmp3;
		logic cmp2;
		logic cmp1;
	} event_src_type;

	typedef struct packed {
		blank_state_type state;
		logic [7:0] fall_blank_source_select;
		logic [7:0] phase_source_select;
		logic [7:0] blanking_duration;
		logic [15:0] time_base_counter;
		logic [15:0] phase_value;
		logic [7:0] blank_count;
		event_src_type sync1;
		event_src_type sync2;
		event_src_type prev;
		logic fall_prev;
		logic rising_event;
		logic blank_active;
		logic [31:0] prdata;
		logic pready;
	} edge_blank_state_type;
endpackage

`default_nettype wire

// ### rtl/edge_source_blanking.sv
/*
 * edge event source selection and blanking logic with an apb register slave.
 * assumes async comparator and pin inputs, a falling event from the duty logic
 * on pclk, and an apb master that follows the standard two phase protocol.
 */
// Operation
// R1: external input blanked for the blanking time when its blank bit is set
// R2: comparator 3 blanked for the blanking time when its blank bit is set
// R3: comparator 2 blanked for the blanking time when its blank bit is set
// R4: comparator 1 blanked for the blanking time when its blank bit is set
// R5: blank register bits 6 to 4 and 0 read zero, writes ignored
// R6: implemented source bits are read write and reset to zero
// R7: phase external bit makes a rising event when the input goes true
// R8: phase comparator 3 bit makes a rising event when comparator 3 goes true
// R9: phase comparator 2 and 1 bits make rising events on their rising edges
// R10: phase time base bit makes a rising event on counter equal phase
// R11: all enabled rising sources are ORed without priority
// R12: inputs synchronised; blanking counts down from the falling event in clocks
`include "edge_blank_consts.svh"
`default_nettype none

module edge_source_blanking
	import edge_blank_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic external_event_input,
	input wire logic comparator1_out,
	input wire logic comparator2_out,
	input wire logic comparator3_out,
	input wire logic falling_event,
	output logic rising_event,
	output logic blank_active
);

	edge_blank_state_type cur;
	edge_blank_state_type nxt;

	function automatic logic blanked_pass(input logic en, input logic active, input logic src);
		blanked_pass = src & ~(en & active);
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	logic setup;
	logic access_wr;
	event_src_type rise;
	event_src_type gated;
	logic tb_match;
	logic fall_start;

	always_comb begin
		nxt = cur;
		setup = psel & ~penable;
		access_wr = psel & penable & pwrite & cur.pready;
		// two flop synchronisers, only the second stage is read by logic [R12]
		nxt.sync1 = '{external_event_input, comparator3_out, comparator2_out, comparator1_out};
		nxt.sync2 = cur.sync1;
		nxt.prev = cur.sync2;
		rise.ext = cur.sync2.ext & ~cur.prev.ext;
		rise.cmp3 = cur.sync2.cmp3 & ~cur.prev.cmp3;
		rise.cmp2 = cur.sync2.cmp2 & ~cur.prev.cmp2;
		rise.cmp1 = cur.sync2.cmp1 & ~cur.prev.cmp1;
		gated.ext = blanked_pass(cur.fall_blank_source_select[`SRC_EXT_BIT],
			cur.blank_active, rise.ext); // [R1]
		gated.cmp3 = blanked_pass(cur.fall_blank_source_select[`SRC_CMP3_BIT],
			cur.blank_active, rise.cmp3); // [R2]
		gated.cmp2 = blanked_pass(cur.fall_blank_source_select[`SRC_CMP2_BIT],
			cur.blank_active, rise.cmp2); // [R3]
		gated.cmp1 = blanked_pass(cur.fall_blank_source_select[`SRC_CMP1_BIT],
			cur.blank_active, rise.cmp1); // [R4]
		tb_match = cur.time_base_counter == cur.phase_value;
		nxt.rising_event = (gated.ext & cur.phase_source_select[`SRC_EXT_BIT]) // [R7] [R11]
			| (gated.cmp3 & cur.phase_source_select[`SRC_CMP3_BIT]) // [R8]
			| (gated.cmp2 & cur.phase_source_select[`SRC_CMP2_BIT]) // [R9]
			| (gated.cmp1 & cur.phase_source_select[`SRC_CMP1_BIT]) // [R9]
			| (tb_match & cur.phase_source_select[`SRC_TB_BIT]); // [R10]
		nxt.fall_prev = falling_event;
		fall_start = falling_event & ~cur.fall_prev;
		// blanking window: start on a falling event, count the duration down [R12]
		case (cur.state)
			st_idle_type: begin
				if (fall_start && cur.blanking_duration != `BLANK_ZERO) begin
					nxt.state = st_blank_type;
					nxt.blank_count = cur.blanking_duration;
					nxt.blank_active = 1'b1;
				end
			end
			st_blank_type: begin
				// a reload with a zero duration ends the window at once
				if (fall_start && cur.blanking_duration == `BLANK_ZERO) begin
					nxt.state = st_idle_type;
					nxt.blank_count = `BLANK_ZERO;
					nxt.blank_active = 1'b0;
				end else if (fall_start) begin
					nxt.blank_count = cur.blanking_duration;
				end else if (cur.blank_count == `BLANK_ONE) begin
					nxt.state = st_idle_type;
					nxt.blank_count = `BLANK_ZERO;
					nxt.blank_active = 1'b0;
				end else begin
					nxt.blank_count = cur.blank_count - `BLANK_ONE;
				end
			end
			default: begin
				nxt.state = st_idle_type;
				nxt.blank_count = `BLANK_ZERO;
				nxt.blank_active = 1'b0;
			end
		endcase
		// apb: no wait state, pready raised in the first access cycle after setup
		nxt.pready = setup;
		if (access_wr) begin
			case (paddr)
				`FBS_OFFSET: nxt.fall_blank_source_select = pwdata[7:0] & `FBS_MASK; // [R5] [R6]
				`PHS_OFFSET: nxt.phase_source_select = pwdata[7:0] & `PHS_MASK; // [R6]
				`BLANK_OFFSET: nxt.blanking_duration = pwdata[7:0];
				`TIMEBASE_OFFSET: nxt.time_base_counter = pwdata[15:0];
				`PHASEVAL_OFFSET: nxt.phase_value = pwdata[15:0];
				default: nxt.prdata = cur.prdata;
			endcase
		end
		if (setup && !pwrite) begin
			case (paddr)
				`FBS_OFFSET: nxt.prdata = {24'h000000, cur.fall_blank_source_select}; // [R5]
				`PHS_OFFSET: nxt.prdata = {24'h000000, cur.phase_source_select};
				`BLANK_OFFSET: nxt.prdata = {24'h000000, cur.blanking_duration};
				`TIMEBASE_OFFSET: nxt.prdata = {16'h0000, cur.time_base_counter};
				`PHASEVAL_OFFSET: nxt.prdata = {16'h0000, cur.phase_value};
				`STATUS_OFFSET: nxt.prdata = {30'h0000000, cur.rising_event, cur.blank_active};
				default: nxt.prdata = 32'h00000000;
			endcase
		end else if (setup) begin
			nxt.prdata = 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur.state <= st_idle_type;
			cur.fall_blank_source_select <= `REG_RESET; // [R6]
			cur.phase_source_select <= `REG_RESET; // [R6]
			cur.blanking_duration <= `BLANK_RESET;
			cur.time_base_counter <= `WORD_RESET;
			cur.phase_value <= `WORD_RESET;
			cur.blank_count <= `BLANK_ZERO;
			cur.sync1 <= '0;
			cur.sync2 <= '0;
			cur.prev <= '0;
			cur.fall_prev <= 1'b0;
			cur.rising_event <= 1'b0;
			cur.blank_active <= 1'b0;
			cur.prdata <= 32'h00000000;
			cur.pready <= 1'b0;
		end else begin
			cur <= nxt;
		end
	end

	assign prdata = cur.prdata;
	assign pready = cur.pready;
	assign pslverr = 1'b0;
	assign rising_event = cur.rising_event;
	assign blank_active = cur.blank_active;

	////////////////////////////////////////////////////////////////////////////////

	fbs_reserved_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
		(cur.fall_blank_source_select & ~`FBS_MASK) == 8'h00)
		else $error("reserved blank source bits set");

	phs_reserved_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
		(cur.phase_source_select & ~`PHS_MASK) == 8'h00)
		else $error("reserved phase source bits set");

	blank_ext_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
		(cur.blank_active && cur.fall_blank_source_select[7]
		&& cur.phase_source_select == 8'h80) |=> !rising_event)
		else $error("external input passed while blanked");

	blank_cmp3_a: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
		(cur.blank_active && cur.fall_blank_source_select[3]
		&& cur.phase_source_select == 8'h08) |=> !rising_event)
		else $error("comparator 3 passed while blanked");

	blank_cmp2_a: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
		(cur.blank_active && cur.fall_blank_source_select[2]
		&& cur.phase_source_select == 8'h04) |=> !rising_event)
		else $error("comparator 2 passed while blanked");

	blank_cmp1_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
		(cur.blank_active && cur.fall_blank_source_select[1]
		&& cur.phase_source_select == 8'h02) |=> !rising_event)
		else $error("comparator 1 passed while blanked");

	ext_rise_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
		(cur.sync2.ext && !cur.prev.ext && cur.phase_source_select[7]
		&& !(cur.blank_active && cur.fall_blank_source_select[7])) |=> rising_event)
		else $error("external rise made no rising event");

	cmp3_rise_a: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		(cur.sync2.cmp3 && !cur.prev.cmp3 && cur.phase_source_select[3]
		&& !(cur.blank_active && cur.fall_blank_source_select[3])) |=> rising_event)
		else $error("comparator 3 rise made no rising event");

	cmp2_rise_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
		(cur.sync2.cmp2 && !cur.prev.cmp2 && cur.phase_source_select[2]
		&& !(cur.blank_active && cur.fall_blank_source_select[2])) |=> rising_event)
		else $error("comparator 2 rise made no rising event");

	cmp1_rise_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
		(cur.sync2.cmp1 && !cur.prev.cmp1 && cur.phase_source_select[1]
		&& !(cur.blank_active && cur.fall_blank_source_select[1])) |=> rising_event)
		else $error("comparator 1 rise made no rising event");

	ext_off_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
		(cur.phase_source_select == 8'h80 && !(cur.sync2.ext && !cur.prev.ext))
		|=> !rising_event)
		else $error("rising event without an external rise");

	cmp3_off_a: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		(cur.phase_source_select == 8'h08 && !(cur.sync2.cmp3 && !cur.prev.cmp3))
		|=> !rising_event)
		else $error("rising event without a comparator 3 rise");

	cmp2_off_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
		(cur.phase_source_select == 8'h04 && !(cur.sync2.cmp2 && !cur.prev.cmp2))
		|=> !rising_event)
		else $error("rising event without a comparator 2 rise");

	cmp1_off_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
		(cur.phase_source_select == 8'h02 && !(cur.sync2.cmp1 && !cur.prev.cmp1))
		|=> !rising_event)
		else $error("rising event without a comparator 1 rise");

	tb_rise_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
		(cur.time_base_counter == cur.phase_value && cur.phase_source_select[0])
		|=> rising_event)
		else $error("time base match made no rising event");

	tb_off_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
		(cur.phase_source_select == 8'h01 && cur.time_base_counter != cur.phase_value)
		|=> !rising_event)
		else $error("rising event without a time base match");

	no_source_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9] [R11]
		(cur.phase_source_select == 8'h00) |=> !rising_event)
		else $error("rising event with no source enabled");

	or_any_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
		(cur.phase_source_select == 8'h8E && !cur.blank_active
		&& cur.sync2.cmp1 && !cur.prev.cmp1) |=> rising_event)
		else $error("one source of several made no rising event");

	blank_start_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		(fall_start && cur.blanking_duration != `BLANK_ZERO)
		|=> (blank_active && cur.blank_count == $past(cur.blanking_duration)))
		else $error("blanking window did not start");

	blank_end_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		(cur.state == st_blank_type && !fall_start && cur.blank_count == `BLANK_ONE)
		|=> !blank_active)
		else $error("blanking window did not end");

	blank_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		(fall_start && cur.blanking_duration == `BLANK_ZERO) |=> !blank_active)
		else $error("blanking with zero duration");

	blank_count_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		(cur.state == st_blank_type && !fall_start && cur.blank_count > `BLANK_ONE)
		|=> cur.blank_count == ($past(cur.blank_count) - `BLANK_ONE))
		else $error("blanking count did not step down");

	blank_state_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		blank_active == (cur.state == st_blank_type))
		else $error("blank flag disagrees with state");

	state_onehot_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		$onehot(cur.state))
		else $error("blanking state not one hot");

	sync_chain_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		cur.sync2 == $past(cur.sync1) && cur.prev == $past(cur.sync2))
		else $error("synchroniser chain skipped a stage");

	pready_setup_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
		(psel && !penable) |=> pready)
		else $error("no ready after setup");

	pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
		pready |=> !pready)
		else $error("ready held longer than one cycle");

	fbs_read_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
		(pready && psel && penable && !pwrite && paddr == `FBS_OFFSET)
		|-> (prdata & ~{24'h000000, `FBS_MASK}) == 32'h00000000)
		else $error("blank source read shows reserved bits");

	phs_read_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
		(pready && psel && penable && !pwrite && paddr == `PHS_OFFSET)
		|-> (prdata & ~{24'h000000, `PHS_MASK}) == 32'h00000000)
		else $error("phase source read shows reserved bits");

	fbs_write_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5] [R6]
		(pready && psel && penable && pwrite && paddr == `FBS_OFFSET)
		|=> cur.fall_blank_source_select == ($past(pwdata[7:0]) & `FBS_MASK))
		else $error("blank source write did not land");

	phs_write_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
		(pready && psel && penable && pwrite && paddr == `PHS_OFFSET)
		|=> cur.phase_source_select == ($past(pwdata[7:0]) & `PHS_MASK))
		else $error("phase source write did not land");

endmodule

`default_nettype wire

// ### verif/edge_src_model.sv
/*
 * far side model: the event pin and three comparator outputs.
 * assumes the bench requests levels in pclk order {ext, cmp3, cmp2, cmp1}.
 */
`default_nettype none
module edge_src_model
	import edge_blank_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] req,
	output logic ext,
	output logic cmp3,
	output logic cmp2,
	output logic cmp1
);
	timeunit 1ns;
	timeprecision 1ps;
	// lines idle low between events, as a settled comparator would
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) {ext, cmp3, cmp2, cmp1} <= 4'h0;
		else {ext, cmp3, cmp2, cmp1} <= req;
	end
endmodule
`default_nettype wire

// ### verif/edge_source_blanking_tb_top.sv
/*
 * self-checking bench for the edge source and blanking block.
 * assumes a zero wait state apb slave and the offsets of the constants header.
 */
`include "edge_blank_consts.svh"
`default_nettype none
module edge_source_blanking_tb_top;
	import edge_blank_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, falling_event = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, rising_event, blank_active, ext, c1, c2, c3;
	logic [3:0] req = 4'h0;
	int err_total = 0, comparisons = 0, cnt;
	logic [7:0] bits [4] = '{8'h80, 8'h08, 8'h04, 8'h02};
	always #10 pclk = ~pclk;
	edge_src_model u_src (.pclk(pclk), .presetn(presetn), .req(req), .ext(ext),
		.cmp3(c3), .cmp2(c2), .cmp1(c1));
	edge_source_blanking u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .external_event_input(ext),
		.comparator1_out(c1), .comparator2_out(c2), .comparator3_out(c3),
		.falling_event(falling_event), .rising_event(rising_event),
		.blank_active(blank_active));
	////////////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		if (pready !== 1'b1) err_total++;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask
	// pulse the chosen sources and count rising events that follow
	task automatic fire(input logic [3:0] s);
		cnt = 0;
		@(posedge pclk); req <= s;
		@(posedge pclk); @(posedge pclk); req <= 4'h0;
		repeat (12) begin
			@(negedge pclk);
			if (rising_event === 1'b1) cnt++;
		end
	endtask
	// one cycle pulse on the falling event input
	task automatic fall;
		@(posedge pclk) falling_event <= 1'b1;
		@(posedge pclk) falling_event <= 1'b0;
	endtask
	task automatic summarize;
		$display("counts: %0d compares, %0d mismatches", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		err_total++;
		summarize();
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `FBS_OFFSET, 0); chk(rd, 32'h0);
		apb(0, `PHS_OFFSET, 0); chk(rd, 32'h0);
		apb(1, `FBS_OFFSET, 32'hFF); apb(0, `FBS_OFFSET, 0); chk(rd, 32'h8E);
		apb(1, `PHS_OFFSET, 32'hFF); apb(0, `PHS_OFFSET, 0); chk(rd, 32'h8F);
		apb(0, 12'h0F0, 0); chk(rd, 32'h0);
		chk(pslverr, 1'b0);
		$display("test registers done");
		apb(1, `BLANK_OFFSET, 32'h28);
		apb(0, `BLANK_OFFSET, 0); chk(rd, 32'h28);
		apb(1, `PHS_OFFSET, 32'h0); fire(4'h8); chk(cnt, 0);
		for (int i = 0; i < 4; i++) begin
			apb(1, `PHS_OFFSET, bits[i]); apb(1, `FBS_OFFSET, 32'h0);
			fire(4'h8 >> i); chk(cnt, 1);
			apb(1, `FBS_OFFSET, bits[i]);
			@(posedge pclk) falling_event <= 1'b1;
			@(posedge pclk) falling_event <= 1'b0;
			fire(4'h8 >> i); chk(cnt, 0);
			chk(blank_active, 1);
			apb(0, `STATUS_OFFSET, 0); chk(rd, 32'h1);
			repeat (40) @(posedge pclk);
			fire(4'h8 >> i); chk(cnt, 1);
		end
		apb(1, `PHS_OFFSET, 32'h8E); fire(4'hF); chk(cnt, 1);
		$display("test sources done");
		apb(1, `TIMEBASE_OFFSET, 32'h5); apb(1, `PHASEVAL_OFFSET, 32'h5);
		apb(1, `PHS_OFFSET, 32'h1); repeat (3) @(negedge pclk);
		chk(rising_event, 1);
		apb(1, `PHASEVAL_OFFSET, 32'h6); repeat (3) @(negedge pclk);
		chk(rising_event, 0);
		$display("test time base done");
		@(posedge pclk) presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `FBS_OFFSET, 0); chk(rd, 32'h0);
		apb(0, `PHS_OFFSET, 0); chk(rd, 32'h0);
		fall(); @(negedge pclk); chk(blank_active, 0);
		apb(1, `BLANK_OFFSET, 32'h3); fall(); cnt = 0;
		repeat (8) begin
			@(negedge pclk);
			if (blank_active === 1'b1) cnt++;
		end
		chk(cnt, 3);
		apb(1, `BLANK_OFFSET, 32'h28); fall(); apb(1, `BLANK_OFFSET, 32'h0); fall();
		@(negedge pclk); chk(blank_active, 0);
		$display("test reset and window done");
		summarize();
	end
endmodule
`default_nettype wire
